// file: src/mcc_pkg.sv
// Contract
// (RQ1) wait mode leaves controller and counter running
// (RQ2) active-halt: counter runs, registers frozen
// (RQ3) full halt freezes counter and registers
// (RQ4) irq needs flag, enable, unmasked cpu
// (RQ5) time-base wakes active-halt, never full halt
// (RQ6) clock-out select drives oscillator clock out
// (RQ7) clock-out stopped during active-halt
// (RQ8) divider code selects osc/2,4,8,16
// (RQ9) slow select picks divided or full clock
// (RQ10) time-base code selects 16000..200000 cycle period
// (RQ11) period change applies at period end
// (RQ12) halt with irq enable enters active-halt
// (RQ13) flag set on overflow, cleared by read
// (RQ14) software avoids bit set/clear on status
// (RQ15) software writes zeros to upper tone bits
// (RQ16) bit 3 drives adc sample stretch
// (RQ17) bit 2 drives adc irq enable
// (RQ18) tone code: off, ~2k, ~1k, ~500 Hz
// (RQ19) tone keeps running in active-halt
// (RQ20) tone toggles every 2000/4000/8000 cycles
// (RQ21) overflow beats read clear; counter restarts
package mcc_pkg;
  localparam logic [7:0] CSR_OFFSET  = 8'h2c;
  localparam logic [7:0] TONE_OFFSET = 8'h2d;
  localparam logic [7:0] CSR_RESET   = 8'h00;
  localparam logic [7:0] TONE_RESET  = 8'h00;

  localparam int CLKOUT_BIT  = 7;
  localparam int CPUDIV_LSB  = 5;
  localparam int SLOW_BIT    = 4;
  localparam int TBSEL_LSB   = 2;
  localparam int TBIE_BIT    = 1;
  localparam int TBFLAG_BIT  = 0;
  localparam int STRETCH_BIT = 3;
  localparam int ADC_IRQ_ENABLE_BIT   = 2;
  localparam int TONESEL_LSB = 0;

  localparam int TB_W   = 18;
  localparam int TONE_W = 13;
  localparam int PRE_W  = 4;

  localparam int unsigned TB_PERIOD_0 = 16000;
  localparam int unsigned TB_PERIOD_1 = 32000;
  localparam int unsigned TB_PERIOD_2 = 80000;
  localparam int unsigned TB_PERIOD_3 = 200000;
  localparam int unsigned TONE_HALF_1 = 2000;
  localparam int unsigned TONE_HALF_2 = 4000;
  localparam int unsigned TONE_HALF_3 = 8000;

  typedef enum logic [1:0] {PWR_RUN, PWR_ACTIVE_HALT, PWR_FULL_HALT} pwr_state_t;
endpackage : mcc_pkg

// file: src/tone_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tone_gen #(
  parameter int unsigned HALF_1 = mcc_pkg::TONE_HALF_1,
  parameter int unsigned HALF_2 = mcc_pkg::TONE_HALF_2,
  parameter int unsigned HALF_3 = mcc_pkg::TONE_HALF_3
) (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  output logic            tone_o
);
  import mcc_pkg::*;

  logic [TONE_W-1:0] cnt_q;
  logic [TONE_W-1:0] cnt_d;
  logic [TONE_W-1:0] half_w;
  logic [1:0]        sel_q;
  logic              tone_q;
  logic              tone_d;
  logic              restart_w;
  logic              flip_w;

  // half period per code; code 0 parks the pin low
  assign half_w = (sel_i == 2'h1) ? TONE_W'(HALF_1 - 1) : // RQ20
                  (sel_i == 2'h2) ? TONE_W'(HALF_2 - 1) :
                                    TONE_W'(HALF_3 - 1);
  // a new code restarts the wave so no odd first half
  assign restart_w = (sel_i != sel_q) || (sel_i == 2'h0);
  assign flip_w    = (cnt_q >= half_w);
  assign cnt_d     = (restart_w || flip_w) ? '0 : cnt_q + 1'b1;
  assign tone_d    = restart_w ? 1'b0 : (flip_w ? ~tone_q : tone_q); // RQ18

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= '0;
      sel_q  <= 2'h0;
      tone_q <= 1'b0;
    end else if (run_i) begin
      cnt_q  <= cnt_d;
      sel_q  <= sel_i;
      tone_q <= tone_d;
    end
  end

  assign tone_o = tone_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  tone_off_a: assert property ((run_i && sel_i == 2'h0) |=> !tone_o) // RQ18
    else $error("tone active while code is off");
  tone_hold_a: assert property ((run_i && !restart_w && !flip_w) |=> $stable(tone_o)) // RQ20
    else $error("tone toggled before half period");
  tone_cov_c: cover property (run_i && flip_w && !restart_w && sel_i == 2'h1);
endmodule : tone_gen
`default_nettype wire

// file: src/main_clock_rtc_beeper.sv
`timescale 1ns/1ps
`default_nettype none
module main_clock_rtc_beeper #(
  parameter int unsigned TB_PERIOD_0 = mcc_pkg::TB_PERIOD_0,
  parameter int unsigned TB_PERIOD_1 = mcc_pkg::TB_PERIOD_1,
  parameter int unsigned TB_PERIOD_2 = mcc_pkg::TB_PERIOD_2,
  parameter int unsigned TB_PERIOD_3 = mcc_pkg::TB_PERIOD_3,
  parameter int unsigned TONE_HALF_1 = mcc_pkg::TONE_HALF_1,
  parameter int unsigned TONE_HALF_2 = mcc_pkg::TONE_HALF_2,
  parameter int unsigned TONE_HALF_3 = mcc_pkg::TONE_HALF_3
) (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       halt_exec_i,
  input  wire logic       ext_wake_i,
  input  wire logic       irq_masked_i,
  output logic            timebase_irq_o,
  output logic            cpu_clk_en_o,
  output logic            clock_out_en_o,
  output logic            tone_o,
  output logic            adc_sample_stretch_o,
  output logic            adc_irq_enable_o,
  output logic            active_halt_o,
  output logic            full_halt_o
);
  import mcc_pkg::*;

  // register state
  logic              clock_out_select_q;
  logic [1:0]        cpu_divider_sel_q;
  logic              slow_mode_select_q;
  logic [1:0]        timebase_sel_q;
  logic              timebase_irq_enable_q;
  logic              timebase_flag_q;
  logic              adc_sample_stretch_q;
  logic              adc_irq_enable_q;
  logic [1:0]        tone_select_q;

  // time base and power state
  logic [TB_W-1:0]   tb_cnt_q;
  logic [TB_W-1:0]   tb_cnt_d;
  logic [1:0]        tb_active_q;
  logic [PRE_W-1:0]  pre_q;
  pwr_state_t        pwr_q;
  pwr_state_t        pwr_d;

  logic [7:0]        rdata_q;
  logic              irq_q;
  logic              cpu_en_q;
  logic              clkout_q;
  logic              ahalt_q;
  logic              fhalt_q;

  // decode and helper wires
  logic              hit_csr_w;
  logic              hit_tone_w;
  logic              regs_live_w;
  logic              count_live_w;
  logic              wr_csr_w;
  logic              wr_tone_w;
  logic              rd_csr_w;
  logic              tb_wrap_w;
  logic              tb_wake_w;
  logic              flag_d;
  logic              irq_d;
  logic              cpu_en_d;
  logic              clkout_d;
  logic [7:0]        csr_view_w;
  logic [7:0]        tone_view_w;
  logic [7:0]        rdata_d;
  logic [PRE_W-1:0]  pre_mask_w;

  function automatic logic [TB_W-1:0] period_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: period_last = TB_W'(TB_PERIOD_0 - 1);
      2'h1: period_last = TB_W'(TB_PERIOD_1 - 1);
      2'h2: period_last = TB_W'(TB_PERIOD_2 - 1);
      2'h3: period_last = TB_W'(TB_PERIOD_3 - 1);
    endcase
  endfunction : period_last

  // low bits that must all be ones for one slow cpu tick
  function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] cp);
    div_mask = {cp == 2'h3, cp[1], cp != 2'h0, 1'b1};
  endfunction : div_mask

  assign hit_csr_w  = (addr_i == CSR_OFFSET);
  assign hit_tone_w = (addr_i == TONE_OFFSET);

  // registers accept writes only while the cpu runs; frozen in both halts
  assign regs_live_w  = clk_en_i && (pwr_q == PWR_RUN); // RQ2 RQ3
  // counter keeps going in active-halt, stops in full halt
  assign count_live_w = clk_en_i && (pwr_q != PWR_FULL_HALT); // RQ2 RQ3

  assign wr_csr_w  = regs_live_w && wr_i && hit_csr_w;
  assign wr_tone_w = regs_live_w && wr_i && hit_tone_w;
  assign rd_csr_w  = regs_live_w && rd_i && hit_csr_w;

  // period end; counter restarts from zero after it
  assign tb_wrap_w = (tb_cnt_q == period_last(tb_active_q)); // RQ10
  assign tb_cnt_d  = tb_wrap_w ? '0 : tb_cnt_q + 1'b1; // RQ21

  // set beats the clear-on-read in the same cycle
  assign flag_d = tb_wrap_w ? 1'b1 : (rd_csr_w ? 1'b0 : timebase_flag_q); // RQ13 RQ21

  // wait mode has no effect here, so the request also wakes from wait
  assign irq_d = timebase_flag_q && timebase_irq_enable_q && !irq_masked_i; // RQ1 RQ4

  // only the time base may end active-halt besides external sources
  assign tb_wake_w = timebase_flag_q && timebase_irq_enable_q; // RQ5

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_RUN: begin
        if (halt_exec_i) begin
          pwr_d = timebase_irq_enable_q ? PWR_ACTIVE_HALT : PWR_FULL_HALT; // RQ12
        end
      end
      PWR_ACTIVE_HALT: begin
        if (tb_wake_w || ext_wake_i) begin
          pwr_d = PWR_RUN; // RQ5
        end
      end
      PWR_FULL_HALT: begin
        if (ext_wake_i) begin
          pwr_d = PWR_RUN; // RQ3 RQ5
        end
      end
      default: pwr_d = PWR_RUN;
    endcase
  end

  // cpu clock given as an enable; stopped in both halts
  assign pre_mask_w = div_mask(cpu_divider_sel_q); // RQ8
  assign cpu_en_d   = (pwr_d == PWR_RUN) &&
                      (!slow_mode_select_q || ((pre_q & pre_mask_w) == pre_mask_w)); // RQ9

  // pad mux gates the oscillator with this; off in active-halt to save power
  assign clkout_d = clock_out_select_q && (pwr_d == PWR_RUN); // RQ6 RQ7

  assign csr_view_w  = {clock_out_select_q, cpu_divider_sel_q, slow_mode_select_q,
                        timebase_sel_q, timebase_irq_enable_q, timebase_flag_q};
  // upper four bits always read zero
  assign tone_view_w = {4'h0, adc_sample_stretch_q, adc_irq_enable_q, tone_select_q}; // RQ15
  assign rdata_d     = hit_csr_w  ? csr_view_w :
                       hit_tone_w ? tone_view_w : 8'h00;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_out_select_q    <= CSR_RESET[CLKOUT_BIT];
      cpu_divider_sel_q     <= CSR_RESET[CPUDIV_LSB +: 2];
      slow_mode_select_q    <= CSR_RESET[SLOW_BIT];
      timebase_sel_q        <= CSR_RESET[TBSEL_LSB +: 2];
      timebase_irq_enable_q <= CSR_RESET[TBIE_BIT];
    end else if (wr_csr_w) begin
      clock_out_select_q    <= wdata_i[CLKOUT_BIT];
      cpu_divider_sel_q     <= wdata_i[CPUDIV_LSB +: 2];
      slow_mode_select_q    <= wdata_i[SLOW_BIT];
      timebase_sel_q        <= wdata_i[TBSEL_LSB +: 2];
      timebase_irq_enable_q <= wdata_i[TBIE_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adc_sample_stretch_q <= TONE_RESET[STRETCH_BIT];
      adc_irq_enable_q     <= TONE_RESET[ADC_IRQ_ENABLE_BIT];
      tone_select_q        <= TONE_RESET[TONESEL_LSB +: 2];
    end else if (wr_tone_w) begin
      adc_sample_stretch_q <= wdata_i[STRETCH_BIT]; // RQ16
      adc_irq_enable_q     <= wdata_i[ADC_IRQ_ENABLE_BIT]; // RQ17
      tone_select_q        <= wdata_i[TONESEL_LSB +: 2];
    end
  end

  // a new period choice is picked up only at the wrap, so no time shift
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tb_cnt_q        <= '0;
      tb_active_q     <= CSR_RESET[TBSEL_LSB +: 2];
      timebase_flag_q <= CSR_RESET[TBFLAG_BIT];
    end else if (count_live_w) begin
      tb_cnt_q        <= tb_cnt_d;
      timebase_flag_q <= flag_d;
      if (tb_wrap_w) begin
        tb_active_q <= timebase_sel_q; // RQ11
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q    <= PWR_RUN;
      pre_q    <= '0;
      irq_q    <= 1'b0;
      cpu_en_q <= 1'b0;
      clkout_q <= 1'b0;
      rdata_q  <= 8'h00;
      ahalt_q  <= 1'b0;
      fhalt_q  <= 1'b0;
    end else if (clk_en_i) begin
      pwr_q    <= pwr_d;
      pre_q    <= pre_q + 1'b1;
      irq_q    <= irq_d;
      cpu_en_q <= cpu_en_d;
      clkout_q <= clkout_d;
      // state flags taken from the next state so the pins come from flops
      ahalt_q  <= (pwr_d == PWR_ACTIVE_HALT);
      fhalt_q  <= (pwr_d == PWR_FULL_HALT);
      if (rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // tone runs on in active-halt; full halt or a low clock enable stops it
  tone_gen #(
    .HALF_1 (TONE_HALF_1),
    .HALF_2 (TONE_HALF_2),
    .HALF_3 (TONE_HALF_3)
  ) u_tone (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .run_i    (count_live_w), // RQ19
    .sel_i    (tone_select_q),
    .tone_o   (tone_o)
  );

  assign rdata_o              = rdata_q;
  assign timebase_irq_o       = irq_q;
  assign cpu_clk_en_o         = cpu_en_q;
  assign clock_out_en_o       = clkout_q;
  assign adc_sample_stretch_o = adc_sample_stretch_q;
  assign adc_irq_enable_o     = adc_irq_enable_q;
  assign active_halt_o        = ahalt_q;
  assign full_halt_o          = fhalt_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  irq_gate_a: assert property (clk_en_i |=> // RQ4
    timebase_irq_o == $past(timebase_flag_q && timebase_irq_enable_q && !irq_masked_i))
    else $error("irq output does not follow flag, enable and mask");

  read_clear_a: assert property ((rd_csr_w && !tb_wrap_w) |=> !timebase_flag_q) // RQ13
    else $error("status read did not clear the flag");

  set_wins_a: assert property ((count_live_w && tb_wrap_w) |=> timebase_flag_q) // RQ21
    else $error("overflow lost");

  halt_freeze_a: assert property ((clk_en_i && pwr_q == PWR_FULL_HALT) |=> // RQ3
    $stable(tb_cnt_q) && $stable(csr_view_w) && $stable(tone_view_w))
    else $error("state changed in full halt");

  ahalt_freeze_a: assert property ((clk_en_i && pwr_q == PWR_ACTIVE_HALT) |=> // RQ2
    $stable(tone_view_w) && $stable(csr_view_w[7:1]) && (tb_cnt_q != $past(tb_cnt_q)))
    else $error("active-halt did not freeze registers or stalled counter");

  // clkout flop and state move together, so this holds in every active-halt cycle
  clkout_stop_a: assert property ((pwr_q == PWR_ACTIVE_HALT) |-> // RQ7
    !clock_out_en_o)
    else $error("clock-out running in active-halt");

  ahalt_entry_a: assert property ((regs_live_w && halt_exec_i && timebase_irq_enable_q) |=> // RQ12
    active_halt_o)
    else $error("halt with irq enable missed active-halt");

  no_tb_wake_a: assert property ((clk_en_i && pwr_q == PWR_FULL_HALT && !ext_wake_i) |=> // RQ5
    full_halt_o)
    else $error("full halt left without external wake");

  period_hold_a: assert property ((count_live_w && !tb_wrap_w) |=> $stable(tb_active_q)) // RQ11
    else $error("period changed before period end");

  fast_cpu_a: assert property ((clk_en_i && !slow_mode_select_q && pwr_d == PWR_RUN) |=> // RQ9
    cpu_clk_en_o)
    else $error("cpu clock gated in normal mode");

  // output, bus and counter checks
  clkout_on_a: assert property ((clk_en_i && clock_out_select_q && pwr_d == PWR_RUN) |=> // RQ6
    clock_out_en_o)
    else $error("clock-out not driven while selected");

  clkout_free_a: assert property ((clk_en_i && !clock_out_select_q) |=> // RQ6
    !clock_out_en_o)
    else $error("clock-out driven while pin is free");

  halt_cpu_off_a: assert property ((pwr_q != PWR_RUN) |-> // RQ2 RQ3
    !cpu_clk_en_o)
    else $error("cpu clock running in a halt state");

  slow_gap_a: assert property ((clk_en_i && slow_mode_select_q && cpu_divider_sel_q == 2'h3 && pre_q != 4'hf) |=> // RQ8
    !cpu_clk_en_o)
    else $error("extra cpu tick in divide-by-16");

  slow_half_a: assert property ((clk_en_i && slow_mode_select_q && cpu_divider_sel_q == 2'h0 && !pre_q[0]) |=> // RQ8
    !cpu_clk_en_o)
    else $error("extra cpu tick in divide-by-2");

  wrap_restart_a: assert property ((count_live_w && tb_wrap_w) |=> // RQ21
    (tb_cnt_q == '0))
    else $error("counter did not restart after overflow");

  count_step_a: assert property ((count_live_w && !tb_wrap_w) |=> // RQ10
    (tb_cnt_q == TB_W'($past(tb_cnt_q) + 1'b1)))
    else $error("counter skipped a step");

  count_bound_a: assert property (tb_cnt_q <= period_last(tb_active_q)) // RQ10
    else $error("counter ran past the period");

  stretch_out_a: assert property (wr_tone_w |=> // RQ16
    (adc_sample_stretch_o == $past(wdata_i[STRETCH_BIT])))
    else $error("sample stretch output wrong");

  adc_ie_out_a: assert property (wr_tone_w |=> // RQ17
    (adc_irq_enable_o == $past(wdata_i[ADC_IRQ_ENABLE_BIT])))
    else $error("adc irq enable output wrong");

  ahalt_wake_a: assert property ((clk_en_i && pwr_q == PWR_ACTIVE_HALT && tb_wake_w) |=> // RQ5
    !active_halt_o)
    else $error("time base did not end active-halt");

  fhalt_entry_a: assert property ((regs_live_w && halt_exec_i && !timebase_irq_enable_q) |=> // RQ12
    full_halt_o)
    else $error("halt without irq enable missed full halt");

  irq_no_en_a: assert property ((clk_en_i && !timebase_irq_enable_q) |=> // RQ4
    !timebase_irq_o)
    else $error("irq raised with enable clear");

  freeze_en_a: assert property (!clk_en_i |=> // RQ10
    ($stable(tb_cnt_q) && $stable(cpu_clk_en_o) && $stable(tone_o) && $stable(csr_view_w)))
    else $error("state moved while clock enable low");

  rdata_csr_a: assert property ((clk_en_i && rd_i && hit_csr_w) |=> // RQ13
    (rdata_o == $past(csr_view_w)))
    else $error("status read data wrong");

  // main scenarios
  wrap_cov_c: cover property (count_live_w && tb_wrap_w && rd_csr_w);
  fhalt_wake_c: cover property (clk_en_i && pwr_q == PWR_FULL_HALT && ext_wake_i);
  ahalt_wake_c: cover property (clk_en_i && pwr_q == PWR_ACTIVE_HALT && tb_wake_w);
  slow_cov_c: cover property (clk_en_i && slow_mode_select_q && cpu_divider_sel_q == 2'h3 && cpu_en_d);
endmodule : main_clock_rtc_beeper
`default_nettype wire

// file: dv/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic clock_i,
  input  wire logic arst_n_i,
  input  wire logic mask_req_i,
  input  wire logic halt_req_i,
  input  wire logic wake_req_i,
  output logic      masked_o,
  output logic      halt_o,
  output logic      wake_o
);
  // core answers one edge late, as a real pipeline would
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      masked_o <= 1'b0;
      halt_o   <= 1'b0;
      wake_o   <= 1'b0;
    end else begin
      masked_o <= mask_req_i;
      halt_o   <= halt_req_i;
      wake_o   <= wake_req_i;
    end
  end
endmodule : cpu_model
`default_nettype wire

// file: dv/main_clock_rtc_beeper_test.sv
`timescale 1ns/1ps
`default_nettype none
module main_clock_rtc_beeper_test;
  import mcc_pkg::*;
  localparam int unsigned PER[4]  = '{16, 32, 80, 200};
  localparam int unsigned HALF[4] = '{0, 4, 8, 16};
  logic       clock_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       mask_req = 1'b0;
  logic       halt_req = 1'b0;
  logic       wake_req = 1'b0;
  logic       clk_en = 1'b1;
  logic       masked, halt_x, wake;
  logic [7:0] rdata_o;
  logic       timebase_irq_o, cpu_clk_en_o, clock_out_en_o, tone_o;
  logic       adc_sample_stretch_o, adc_irq_enable_o, active_halt_o, full_halt_o;
  logic       irq_q = 1'b0;
  logic       tone_q = 1'b0;
  int         cyc = 0, irq_t = 0, irq_dt = 0, tone_t = 0, tone_dt = 0;
  int         num_errors = 0;
  int         checked = 0;

  main_clock_rtc_beeper #(.TB_PERIOD_0(PER[0]), .TB_PERIOD_1(PER[1]), .TB_PERIOD_2(PER[2]),
    .TB_PERIOD_3(PER[3]), .TONE_HALF_1(HALF[1]), .TONE_HALF_2(HALF[2]), .TONE_HALF_3(HALF[3])) dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_exec_i(halt_x), .ext_wake_i(wake),
    .irq_masked_i(masked), .timebase_irq_o(timebase_irq_o), .cpu_clk_en_o(cpu_clk_en_o),
    .clock_out_en_o(clock_out_en_o), .tone_o(tone_o), .adc_sample_stretch_o(adc_sample_stretch_o),
    .adc_irq_enable_o(adc_irq_enable_o), .active_halt_o(active_halt_o), .full_halt_o(full_halt_o));

  cpu_model cpu_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .mask_req_i(mask_req), .halt_req_i(halt_req),
    .wake_req_i(wake_req), .masked_o(masked), .halt_o(halt_x), .wake_o(wake));

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  // edge times of irq and tone, one edge behind the outputs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    irq_q <= timebase_irq_o;
    tone_q <= tone_o;
    if (timebase_irq_o === 1'b1 && irq_q === 1'b0) begin
      irq_dt <= cyc - irq_t;
      irq_t <= cyc;
    end
    if (tone_o !== tone_q) begin
      tone_dt <= cyc - tone_t;
      tone_t <= cyc;
    end
  end

  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // whole bytes only, tone bits 7:4 kept zero
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // one-cycle request to the core model: halt or wake
  task pulse(input bit wake_sel);
    @(posedge clock_i);
    if (wake_sel) begin
      wake_req <= 1'b1;
    end else begin
      halt_req <= 1'b1;
    end
    @(posedge clock_i);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask : pulse

  // clears the flag, then waits for the next request
  task wait_irq;
    logic [7:0] d;
    int         i;
    rd(CSR_OFFSET, d);
    @(posedge clock_i);
    #1;
    for (i = 0; i < 300 && timebase_irq_o !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk("irq_wait", timebase_irq_o, 1);
    @(posedge clock_i);
    #1;
  endtask : wait_irq

  task t_regs;
    logic [7:0] d;
    rd(CSR_OFFSET, d);
    chk("csr_reset", d, CSR_RESET);
    rd(TONE_OFFSET, d);
    chk("tone_reset", d, TONE_RESET);
    rd(8'h2e, d);
    chk("unmapped", d, 8'h00);
    wr(TONE_OFFSET, 8'h08);
    wr(CSR_OFFSET, 8'h80);
    #1;
    chk("stretch", {adc_sample_stretch_o, adc_irq_enable_o}, 2'h2);
    wr(TONE_OFFSET, 8'h04);
    #1;
    chk("adc_ie", {adc_sample_stretch_o, adc_irq_enable_o}, 2'h1);
    chk("clk_out", clock_out_en_o, 1);
    rd(TONE_OFFSET, d);
    chk("tone_rb", d, 8'h04);
  endtask : t_regs

  task t_div;
    int c, n, i;
    for (c = 0; c < 5; c++) begin
      wr(CSR_OFFSET, c < 4 ? {1'b0, c[1:0], 5'h10} : 8'h00);
      repeat (2) @(posedge clock_i);
      n = 0;
      for (i = 0; i < 64; i++) begin
        @(posedge clock_i);
        #1;
        n += (cpu_clk_en_o === 1'b1);
      end
      chk("cpu_ticks", n, c < 4 ? 32 >> c : 64);
    end
    chk("clk_free", clock_out_en_o, 0);
  endtask : t_div

  task t_tone;
    int c;
    for (c = 1; c < 4; c++) begin
      wr(TONE_OFFSET, {6'h00, c[1:0]});
      repeat (60) @(posedge clock_i);
      chk("tone_half", tone_dt, HALF[c]);
    end
    wr(TONE_OFFSET, 8'h00);
    repeat (3) @(posedge clock_i);
    #1;
    chk("tone_off", tone_o, 0);
  endtask : t_tone

  task t_period;
    logic [7:0] d;
    int         c;
    for (c = 0; c < 4; c++) begin
      wr(CSR_OFFSET, {4'h0, c[1:0], 2'h2});
      wait_irq();
      if (c > 0) chk("tb_old", irq_dt, PER[c-1]);
      wait_irq();
      chk("tb_period", irq_dt, PER[c]);
      rd(CSR_OFFSET, d);
      chk("flag_set", d[0], 1);
      rd(CSR_OFFSET, d);
      chk("flag_clr", d[0], 0);
    end
  endtask : t_period

  task t_mask;
    logic [7:0] d;
    @(posedge clock_i);
    mask_req <= 1'b1;
    wr(CSR_OFFSET, 8'h02);
    repeat (450) @(posedge clock_i);
    #1;
    chk("irq_masked", timebase_irq_o, 0);
    @(posedge clock_i);
    mask_req <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk("irq_unmask", timebase_irq_o, 1);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, d);
    repeat (40) @(posedge clock_i);
    #1;
    chk("irq_noen", timebase_irq_o, 0);
    rd(CSR_OFFSET, d);
    chk("flag_noen", d[0], 1);
  endtask : t_mask

  // tone and writes stall while the clock enable is low
  task t_freeze;
    logic [7:0] d;
    logic       t0;
    wr(TONE_OFFSET, 8'h01);
    repeat (6) @(posedge clock_i);
    clk_en <= 1'b0;
    @(posedge clock_i);
    #1;
    t0 = tone_o;
    wr(TONE_OFFSET, 8'h02);
    repeat (20) @(posedge clock_i);
    #1;
    chk("frz_tone", tone_o, t0);
    chk("frz_cpu", cpu_clk_en_o, 1);
    @(posedge clock_i);
    clk_en <= 1'b1;
    rd(TONE_OFFSET, d);
    chk("frz_wr", d, 8'h01);
  endtask : t_freeze

  task t_ahalt;
    logic [7:0] d;
    int         t0, i;
    wr(TONE_OFFSET, 8'h01);
    wr(CSR_OFFSET, 8'h86);
    wait_irq();
    wait_irq();
    rd(CSR_OFFSET, d);
    pulse(1'b0);
    repeat (3) @(posedge clock_i);
    #1;
    chk("ahalt", active_halt_o, 1);
    chk("clk_out_ah", clock_out_en_o, 0);
    chk("cpu_ah", cpu_clk_en_o, 0);
    t0 = tone_t;
    wr(TONE_OFFSET, 8'h00);
    repeat (5) @(posedge clock_i);
    #1;
    chk("tone_ah", tone_t != t0, 1);
    for (i = 0; i < 40 && active_halt_o === 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk("ah_wake", active_halt_o, 0);
    rd(TONE_OFFSET, d);
    chk("ah_frozen", d, 8'h01);
  endtask : t_ahalt

  task t_fhalt;
    logic [7:0] d;
    int         t0, i;
    wr(CSR_OFFSET, 8'h00);
    d = 8'h00;
    for (i = 0; i < 60 && d[0] !== 1'b1; i++) rd(CSR_OFFSET, d);
    pulse(1'b0);
    repeat (3) @(posedge clock_i);
    #1;
    chk("fhalt", full_halt_o, 1);
    t0 = tone_t;
    repeat (100) @(posedge clock_i);
    rd(CSR_OFFSET, d);
    chk("fh_count", d[0], 0);
    chk("fh_tone", tone_t, t0);
    chk("fh_stay", full_halt_o, 1);
    pulse(1'b1);
    repeat (4) @(posedge clock_i);
    #1;
    chk("fh_wake", full_halt_o, 0);
    wr(TONE_OFFSET, 8'h00);
    rd(TONE_OFFSET, d);
    chk("fh_resume", d, 8'h00);
  endtask : t_fhalt

  task results;
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // whole run is about two thousand cycles; this is fifteen times that
  initial begin
    #(100 * 30000);
    num_errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_div();
    t_tone();
    t_period();
    t_mask();
    t_freeze();
    t_ahalt();
    t_fhalt();
    results();
  end
endmodule : main_clock_rtc_beeper_test
`default_nettype wire
